// *** acpc_ctrl.sv ***
// converter configuration and analog pin release registers on an avalon-mm slave
`timescale 1ns/1ns
`include "acpc_cfg.svh"
module acpc_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic low_power_select,
  output logic [1:0] clock_divider_select,
  output logic long_sample_select,
  output logic [1:0] resolution_select,
  output logic [1:0] input_clock_select,
  output logic result_invalid,
  input wire logic result_valid_clear,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  input wire logic [15:0] port_pullup,
  input wire logic [15:0] pin_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] pad_pullup,
  output logic [15:0] port_in,
  output logic [15:0] analog_release
);
  typedef struct packed {
    acpc_pkg::acpc_bus_e fsm;
    logic [7:0] cfg;
    logic [7:0] pin_low;
    logic [7:0] pin_mid;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic wreq;
    logic invalid;
  } acpc_ctrl_s;
  acpc_ctrl_s st_r;
  acpc_ctrl_s st_nxt;
  logic [15:0] release_bits;
  logic [7:0] cfg_w;

  assign release_bits = {st_r.pin_mid, st_r.pin_low};

  always_comb begin
    st_nxt = st_r;
    cfg_w = st_r.cfg;
    // waitrequest kept as its own flop so the pin needs no inverter
    st_nxt.wreq = 1'b1;
    // hardware clear from the result side loses to a fresh resolution change
    if (result_valid_clear) begin
      st_nxt.invalid = 1'b0;
    end
    case (st_r.fsm)
      acpc_pkg::ACPC_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.fsm = acpc_pkg::ACPC_BUSY;
        end
      end
      acpc_pkg::ACPC_BUSY: begin
        st_nxt.resp = 2'h0;
        st_nxt.rdata = 32'h0;
        if (avs_write) begin
          case (avs_address)
            `ACPC_OFS_CFG: begin
              if (avs_byteenable[0]) begin
                cfg_w = avs_writedata[7:0];
                st_nxt.cfg = cfg_w;
                if (cfg_w[`ACPC_RES_HI:`ACPC_RES_LO] != st_r.cfg[`ACPC_RES_HI:`ACPC_RES_LO]) begin
                  st_nxt.invalid = 1'b1;
                end
              end
            end
            `ACPC_OFS_PIN_LOW: begin
              if (avs_byteenable[0]) begin
                st_nxt.pin_low = avs_writedata[7:0];
              end
            end
            `ACPC_OFS_PIN_MID: begin
              if (avs_byteenable[0]) begin
                st_nxt.pin_mid = avs_writedata[7:0];
              end
            end
            `ACPC_OFS_STATUS: begin
            end
            default: begin
              st_nxt.resp = 2'h3;
            end
          endcase
        end else begin
          case (avs_address)
            `ACPC_OFS_CFG: st_nxt.rdata = {24'h0, st_r.cfg};
            `ACPC_OFS_PIN_LOW: st_nxt.rdata = {24'h0, st_r.pin_low};
            `ACPC_OFS_PIN_MID: st_nxt.rdata = {24'h0, st_r.pin_mid};
            `ACPC_OFS_STATUS: st_nxt.rdata = {31'h0, st_r.invalid};
            default: st_nxt.resp = 2'h3;
          endcase
        end
        st_nxt.wreq = 1'b0;
        st_nxt.fsm = acpc_pkg::ACPC_DONE;
      end
      acpc_pkg::ACPC_DONE: begin
        // one idle cycle so a held request is not taken twice
        st_nxt.fsm = acpc_pkg::ACPC_IDLE;
      end
      default: begin
        st_nxt.fsm = acpc_pkg::ACPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r.fsm <= acpc_pkg::ACPC_IDLE;
      st_r.cfg <= `ACPC_RST_CFG;
      st_r.pin_low <= `ACPC_RST_PIN;
      st_r.pin_mid <= `ACPC_RST_PIN;
      st_r.rdata <= 32'h0;
      st_r.resp <= 2'h0;
      st_r.wreq <= 1'b1;
      st_r.invalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wreq;
  assign avs_response = st_r.resp;
  assign low_power_select = st_r.cfg[`ACPC_BIT_LOW_POWER];
  assign clock_divider_select = st_r.cfg[`ACPC_DIV_HI:`ACPC_DIV_LO];
  assign long_sample_select = st_r.cfg[`ACPC_BIT_LONG_SAMPLE];
  assign resolution_select = st_r.cfg[`ACPC_RES_HI:`ACPC_RES_LO];
  assign input_clock_select = st_r.cfg[`ACPC_CLK_HI:`ACPC_CLK_LO];
  assign result_invalid = st_r.invalid;
  assign analog_release = release_bits;

  for (genvar i = 0; i < 16; i++) begin : g_pin
    acpc_pin_gate u_gate (
      .core_clk(core_clk),
      .resetn(resetn),
      .release_bit(release_bits[i]),
      .port_out(port_out[i]),
      .port_oe(port_oe[i]),
      .port_pullup(port_pullup[i]),
      .pin_in(pin_in[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .pad_pullup(pad_pullup[i]),
      .port_in(port_in[i])
    );
  end
endmodule : acpc_ctrl

// *** acpc_cfg.svh ***
// offsets, field positions, reset values and timing counts for the converter control block
`ifndef ACPC_CFG_SVH
`define ACPC_CFG_SVH
`define ACPC_OFS_CFG 4'h0
`define ACPC_OFS_PIN_LOW 4'h4
`define ACPC_OFS_PIN_MID 4'h8
`define ACPC_OFS_STATUS 4'hC
`define ACPC_BIT_LOW_POWER 7
`define ACPC_DIV_HI 6
`define ACPC_DIV_LO 5
`define ACPC_BIT_LONG_SAMPLE 4
`define ACPC_RES_HI 3
`define ACPC_RES_LO 2
`define ACPC_CLK_HI 1
`define ACPC_CLK_LO 0
`define ACPC_RST_CFG 8'h00
`define ACPC_RST_PIN 8'h00
`define ACPC_ACCESS_NS 50
`define ACPC_CLK_NS 50
`define ACPC_ACCESS_CYC ((`ACPC_ACCESS_NS + `ACPC_CLK_NS - 1) / `ACPC_CLK_NS)
`endif

// *** acpc_pkg.sv ***
// types shared by the converter control block
package acpc_pkg;
  typedef enum logic [2:0] {
    ACPC_IDLE = 3'b001,
    ACPC_BUSY = 3'b010,
    ACPC_DONE = 3'b100
  } acpc_bus_e;
  typedef enum logic [1:0] {
    ACPC_RES_8 = 2'h0,
    ACPC_RES_12 = 2'h1,
    ACPC_RES_10 = 2'h2,
    ACPC_RES_RSV = 2'h3
  } acpc_res_e;
  typedef enum logic [1:0] {
    ACPC_SRC_BUS = 2'h0,
    ACPC_SRC_BUS_HALF = 2'h1,
    ACPC_SRC_ALT = 2'h2,
    ACPC_SRC_ASYNC = 2'h3
  } acpc_src_e;
endpackage : acpc_pkg

// *** acpc_pin_gate.sv ***
// one analog pin gate: releases port control of a pin while its bit is set
`timescale 1ns/1ns
module acpc_pin_gate (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic release_bit,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic port_pullup,
  input wire logic pin_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic port_in
);
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic sync1;
    logic sync2;
    logic rd;
  } acpc_gate_s;
  acpc_gate_s st_r;
  acpc_gate_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.out = port_out & ~release_bit;
    st_nxt.oe = port_oe & ~release_bit;
    st_nxt.pu = port_pullup & ~release_bit;
    st_nxt.rd = st_r.sync2 & ~release_bit;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad_out = st_r.out;
  assign pad_oe = st_r.oe;
  assign pad_pullup = st_r.pu;
  assign port_in = st_r.rd;
endmodule : acpc_pin_gate

// *** acpc_ctrl_sva.sv ***
// assertions on the converter control block ports
`timescale 1ns/1ns
module acpc_ctrl_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic low_power_select,
  input wire logic [1:0] clock_divider_select,
  input wire logic long_sample_select,
  input wire logic [1:0] resolution_select,
  input wire logic [1:0] input_clock_select,
  input wire logic result_invalid,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] analog_release,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pad_pullup,
  input wire logic [15:0] port_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire wr = !avs_waitrequest && avs_write && avs_byteenable[0];
  // answer edge: store landed one edge earlier
  wire cw = wr && avs_address == 4'h0;
  property p_lp; cw |-> low_power_select == avs_writedata[7]; endproperty
  a_lp: assert property (p_lp) else $error("speed profile");
  property p_dv; cw |-> clock_divider_select == avs_writedata[6:5]; endproperty
  a_dv: assert property (p_dv) else $error("divider");
  property p_ls; cw |-> long_sample_select == avs_writedata[4]; endproperty
  a_ls: assert property (p_ls) else $error("sample time");
  property p_rs; cw |-> resolution_select == avs_writedata[3:2]; endproperty
  a_rs: assert property (p_rs) else $error("resolution");
  property p_ck; cw |-> input_clock_select == avs_writedata[1:0]; endproperty
  a_ck: assert property (p_ck) else $error("clock source");
  property p_lo; wr && avs_address == 4'h4 |=> analog_release[7:0] == $past(avs_writedata[7:0]); endproperty
  a_lo: assert property (p_lo) else $error("low release");
  property p_md; wr && avs_address == 4'h8 |=> analog_release[15:8] == $past(avs_writedata[7:0]); endproperty
  a_md: assert property (p_md) else $error("mid release");
  property p_rl; analog_release == $past(analog_release) |-> (analog_release & (pad_oe | pad_out | pad_pullup | port_in)) == 16'h0; endproperty
  a_rl: assert property (p_rl) else $error("released pin");
  property p_iv; cw && resolution_select != $past(resolution_select) |-> result_invalid; endproperty
  a_iv: assert property (p_iv) else $error("result not marked invalid");
  property p_rt; $rose(resetn) |-> input_clock_select == 2'h0 && resolution_select == 2'h0 && analog_release == 16'h0; endproperty
  a_rt: assert property (p_rt) else $error("reset value");
endmodule : acpc_ctrl_sva
bind acpc_ctrl acpc_ctrl_sva chk_u (.*);

// *** acpc_far.sv ***
// port logic and result logic beside the converter control block
`timescale 1ns/1ns
module acpc_far (
  input wire logic [31:0] rnd,
  input wire logic clr,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  output logic [15:0] port_pullup,
  output logic [15:0] pin_in,
  output logic result_valid_clear
);
  // overlapping slices so released and driven pins mix
  assign port_out = rnd[27:12];
  assign port_oe = rnd[31:16];
  assign port_pullup = rnd[23:8];
  assign pin_in = rnd[19:4];
  assign result_valid_clear = clr;
endmodule : acpc_far

// *** acpc_ctrl_test.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
module acpc_ctrl_test;
  logic core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, clr = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rnd = 32'h0499, avs_readdata;
  logic avs_waitrequest, low_power_select, long_sample_select, result_invalid, result_valid_clear;
  logic [1:0] avs_response, clock_divider_select, resolution_select, input_clock_select;
  logic [15:0] port_out, port_oe, port_pullup, pin_in, pad_out, pad_oe, pad_pullup, port_in, analog_release;
  logic [33:0] exp_q[$];
  int n_fail = 0, comparisons = 0;
  acpc_ctrl dut_u (.*);
  acpc_far far_u (.*);
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // holds the request until waitrequest is seen low, bounded
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      close_out();
    end else begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
    end
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0, 4'hF);
  endtask : rd
  always @(posedge core_clk) if (avs_read && avs_waitrequest === 1'b0) chk({avs_response, avs_readdata}, exp_q.pop_front());
  initial begin
    logic [7:0] v;
    logic [31:0] w;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(4'h0, 34'h0);
    rd(4'h4, 34'h0);
    rd(4'h8, 34'h0);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      w = lfsr(rnd);
      rnd <= w;
      v = {w[7], i[1:0], w[4], i[1:0], i[1:0]};
      bus(1'b0, 4'h0, {24'h0, v}, 4'hF);
      chk({low_power_select, clock_divider_select, long_sample_select, resolution_select, input_clock_select}, v);
      chk(result_invalid, i != 0);
      rd(4'hC, {33'h0, i != 0});
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      @(posedge core_clk);
      chk(result_invalid, 1'b0);
      rd(4'h0, {26'h0, v});
    end
    // lane 0 off means nothing stored
    bus(1'b0, 4'h0, 32'hFF, 4'h0);
    rd(4'h0, {26'h0, v});
    rd(4'h1, {2'h3, 32'h0});
    $display("config done");
    for (int j = 0; j < 3; j++) begin
      w = lfsr(rnd);
      rnd <= w;
      bus(1'b0, 4'h4, {24'h0, w[7:0]}, 4'hF);
      bus(1'b0, 4'h8, {24'h0, w[15:8]}, 4'hF);
      repeat (4) @(posedge core_clk);
      chk(analog_release, w[15:0]);
      chk({pad_oe, pad_out}, {port_oe & ~w[15:0], port_out & ~w[15:0]});
      chk({pad_pullup, port_in}, {port_pullup & ~w[15:0], pin_in & ~w[15:0]});
      rd(4'h8, {26'h0, w[15:8]});
    end
    $display("pin release done");
    // second reset with non-zero registers, so the reset values mean something
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({result_invalid, analog_release}, 17'h0);
    rd(4'h0, 34'h0);
    rd(4'h4, 34'h0);
    rd(4'h8, 34'h0);
    $display("second reset done");
    close_out();
  end
endmodule : acpc_ctrl_test
